// ==== core/maint_pkg.sv ====
// Constants and carrier types for the maintenance step and readback block
package maint_pkg;
	// I/O transfer instruction: device code and operation codes
	localparam logic [5:0] MAINT_DEV_CODE = 6'h2E;
	localparam logic [2:0] OP_MAINT_STEP  = 3'h1;
	localparam logic [2:0] OP_READ_STATES = 3'h2;
	localparam logic [2:0] OP_READ_O_UP   = 3'h3;
	localparam logic [2:0] OP_READ_O_LOW  = 3'h4;
	localparam logic [2:0] OP_READ_PTR    = 3'h5;
	localparam logic [2:0] OP_READ_MQ     = 3'h6;
	localparam logic [2:0] OP_LOAD_SC     = 3'h7;

	// Accumulator field positions, vector index = 11 - host bit number
	localparam int AC_STATE_MSB = 11;
	localparam int AC_STATE_LSB = 8;
	localparam int AC_MAJOR_MSB = 7;
	localparam int AC_MAJOR_LSB = 2;
	localparam int AC_SPECIAL   = 1;
	localparam int AC_XT_EXEC   = 0;
	localparam int AC_XP_SEL    = 11;
	localparam int AC_EXT1_SEL  = 8;
	localparam int AC_EXT2_SEL  = 7;
	localparam int AC_EXT3_SEL  = 6;
	localparam int AC_SC_MSB    = 5;
	localparam int AC_SC_LSB    = 0;

	// O register: numbered bit k sits at vector index 59 - k
	localparam int O_UPPER_TOP = 59;
	localparam int O_LOWER_TOP = 47;
	localparam int O_EXT1_TOP  = 35;
	localparam int O_EXT2_TOP  = 23;
	localparam int O_EXT3_TOP  = 11;

	// Register port map
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam int CTRL_IOT_EN  = 0;
	localparam int STAT_MAINT   = 0;
	localparam int STAT_HALTED  = 1;
	localparam int STAT_XP      = 2;
	localparam int STAT_SC_LSB  = 4;
	localparam int STAT_TS_LSB  = 12;
	localparam logic CTRL_IOT_EN_RESET = 1'b1;

	typedef struct packed {
		logic        valid;
		logic [5:0]  dev;
		logic [2:0]  op;
		logic [11:0] ac;
	} iot_req_t;

	typedef struct packed {
		logic [3:0]  time_state;
		logic [5:0]  major;
		logic        special;
		logic        xt_exec;
		logic [59:0] o_reg;
		logic [11:0] ptr;
		logic [11:0] mq_low;
	} core_view_t;

	typedef struct packed {
		logic [1:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;
endpackage

// ==== core/maintenance_step_readback.sv ====
// Maintenance mode, time state stepping and internal state readback
// Summary of operation
// RULE_01: In maintenance mode, halt at each major time state end and wait.
// RULE_02: Host issues enter-maintenance before start-processor to run stepped from start.
// RULE_03: Enter-maintenance while halted acts as a step to next time state.
// RULE_04: Maintenance mode ends whenever the interrupt request flag clears.
// RULE_05: Every readback ORs its data into the host accumulator.
// RULE_06: Read-states puts time state counter in bits 00-03, bit 00 MSB.
// RULE_07: Read-states bits 04-09 carry deposit, fetch, execute, exit, initiate, process.
// RULE_08: Read-states bits 10-11 report special and extended timing execute states.
// RULE_09: Read O upper word ORs the upper O word into accumulator.
// RULE_10: Read O lower word ORs the lower O word into accumulator.
// RULE_11: Read pointer ORs low 12 bits of parameter table pointer.
// RULE_12: Read multiplier-quotient ORs its low word into accumulator.
// RULE_13: Load shift counter from accumulator bits 06-11, bit 06 MSB.
// RULE_14: Accumulator bit 00 selects extended precision; bits 01-02 ignored.
// RULE_15: Bits 03/04/05 read O bits 24-35/36-47/48-59, lowest to bit 00.
// RULE_16: Load shift counter clears accumulator, leaving only selected extension word.
// RULE_17: Outside maintenance mode states run without halting; step has no effect.
// RULE_18: Without extended precision option, bits 10-11 add zeros to the OR.
//
// The register addresses and strobed register access were decided locally.
module maintenance_step_readback
	import maint_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	input  wire logic        ce_i,
	input  wire logic        ext_option_i,
	input  wire iot_req_t    iot_i,
	input  wire core_view_t  core_i,
	input  wire logic        state_end_i,
	input  wire logic        irq_flag_clear_i,
	input  wire reg_req_t    reg_i,
	output logic [11:0]      ac_o,
	output logic             ac_valid_o,
	output logic             maint_mode_o,
	output logic             halt_o,
	output logic             step_o,
	output logic [5:0]       shift_cnt_o,
	output logic             shift_load_o,
	output logic             ext_prec_o,
	output logic [15:0]      rdata_o
);

	typedef struct packed {
		logic        maint;
		logic        halted;
		logic        step;
		logic        iot_en;
		logic        ext_prec;
		logic [5:0]  sc;
		logic        sc_load;
		logic [11:0] ac;
		logic        ac_valid;
		logic [15:0] rdata;
	} state_t;

	state_t st;
	state_t next_st;
	logic   iot_hit;

	function automatic logic [11:0] o_word(input logic [59:0] o, input int top);
		o_word = o[top -: 12];
	endfunction

	assign iot_hit = iot_i.valid && (iot_i.dev == MAINT_DEV_CODE) && st.iot_en;

	always_comb begin
		logic [11:0] data;
		logic [11:0] ext;
		data = 12'h000;
		ext = 12'h000;
		next_st = st;
		next_st.step = 1'b0;
		next_st.sc_load = 1'b0;
		next_st.ac_valid = 1'b0;
		next_st.rdata = 16'h0000;

		// Halt on state end only in maintenance mode
		if (state_end_i && st.maint && !irq_flag_clear_i) begin // [RULE_01] [RULE_17]
			next_st.halted = 1'b1;
		end

		if (iot_hit) begin
			next_st.ac_valid = 1'b1;
			case (iot_i.op)
				OP_MAINT_STEP: begin
					next_st.maint = 1'b1;
					if (st.halted) begin // [RULE_03]
						next_st.halted = 1'b0;
						next_st.step = 1'b1;
					end
				end
				OP_READ_STATES: begin
					data[AC_STATE_MSB:AC_STATE_LSB] = core_i.time_state; // [RULE_06]
					data[AC_MAJOR_MSB:AC_MAJOR_LSB] = core_i.major; // [RULE_07]
					data[AC_SPECIAL] = core_i.special && ext_option_i; // [RULE_08] [RULE_18]
					data[AC_XT_EXEC] = core_i.xt_exec && ext_option_i; // [RULE_08] [RULE_18]
				end
				OP_READ_O_UP: begin
					data = o_word(core_i.o_reg, O_UPPER_TOP); // [RULE_09]
				end
				OP_READ_O_LOW: begin
					data = o_word(core_i.o_reg, O_LOWER_TOP); // [RULE_10]
				end
				OP_READ_PTR: begin
					data = core_i.ptr; // [RULE_11]
				end
				OP_READ_MQ: begin
					data = core_i.mq_low; // [RULE_12]
				end
				OP_LOAD_SC: begin
					next_st.sc = iot_i.ac[AC_SC_MSB:AC_SC_LSB]; // [RULE_13]
					next_st.sc_load = 1'b1;
					next_st.ext_prec = iot_i.ac[AC_XP_SEL]; // [RULE_14]
					// Several selects at once merge by OR, a harmless corner
					if (iot_i.ac[AC_EXT1_SEL]) begin // [RULE_15]
						ext = ext | o_word(core_i.o_reg, O_EXT1_TOP);
					end
					if (iot_i.ac[AC_EXT2_SEL]) begin // [RULE_15]
						ext = ext | o_word(core_i.o_reg, O_EXT2_TOP);
					end
					if (iot_i.ac[AC_EXT3_SEL]) begin // [RULE_15]
						ext = ext | o_word(core_i.o_reg, O_EXT3_TOP);
					end
				end
				default: begin
					next_st.ac_valid = 1'b0;
				end
			endcase
			if (iot_i.op == OP_LOAD_SC) begin
				next_st.ac = ext; // [RULE_16]
			end else if (next_st.ac_valid) begin
				// Op zero leaves the accumulator as it stands
				next_st.ac = iot_i.ac | data; // [RULE_05]
			end
		end

		// Flag clear wins over entry and state-end halt in the same cycle; a step pulse still issues
		if (irq_flag_clear_i) begin // [RULE_04]
			next_st.maint = 1'b0;
			next_st.halted = 1'b0;
		end

		if (reg_i.wr && reg_i.addr == ADDR_CTRL) begin
			next_st.iot_en = reg_i.wdata[CTRL_IOT_EN];
		end
		if (reg_i.rd) begin
			case (reg_i.addr)
				ADDR_CTRL: begin
					next_st.rdata[CTRL_IOT_EN] = st.iot_en;
				end
				ADDR_STATUS: begin
					next_st.rdata[STAT_MAINT] = st.maint;
					next_st.rdata[STAT_HALTED] = st.halted;
					next_st.rdata[STAT_XP] = st.ext_prec;
					next_st.rdata[STAT_SC_LSB +: 6] = st.sc;
					next_st.rdata[STAT_TS_LSB +: 4] = core_i.time_state;
				end
				default: begin
					next_st.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '0;
			st.iot_en <= CTRL_IOT_EN_RESET;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign ac_o         = st.ac;
	assign ac_valid_o   = st.ac_valid;
	assign maint_mode_o = st.maint;
	assign halt_o       = st.halted;
	assign step_o       = st.step;
	assign shift_cnt_o  = st.sc;
	assign shift_load_o = st.sc_load;
	assign ext_prec_o   = st.ext_prec;
	assign rdata_o      = st.rdata;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	// Stepping and mode
	halt_on_end_a: assert property ( // [RULE_01]
		ce_i && state_end_i && st.maint && !irq_flag_clear_i
		|=> halt_o)
		else $error("No halt at state end in maintenance mode");
	halt_hold_a: assert property ( // [RULE_01]
		ce_i && halt_o && !irq_flag_clear_i && !(iot_hit && iot_i.op == OP_MAINT_STEP)
		|=> halt_o)
		else $error("Halt released without a step");
	no_halt_free_a: assert property ( // [RULE_17]
		ce_i && !st.maint && !(iot_hit && iot_i.op == OP_MAINT_STEP)
		|=> !halt_o)
		else $error("Halted outside maintenance mode");
	halt_in_mode_a: assert property ( // [RULE_17]
		halt_o
		|-> maint_mode_o)
		else $error("Halt flag set without maintenance mode");
	step_free_a: assert property ( // [RULE_17]
		ce_i && iot_hit && iot_i.op == OP_MAINT_STEP && !halt_o
		|=> !step_o)
		else $error("Step pulse while not halted");
	step_release_a: assert property ( // [RULE_03]
		ce_i && iot_hit && iot_i.op == OP_MAINT_STEP && halt_o && !irq_flag_clear_i
		|=> step_o && !halt_o && maint_mode_o)
		else $error("Step did not advance a halted state");
	step_pulse_a: assert property ( // [RULE_03]
		ce_i && !(iot_hit && iot_i.op == OP_MAINT_STEP)
		|=> !step_o)
		else $error("Step pulse without a step command");
	enter_mode_a: assert property ( // [RULE_03]
		ce_i && iot_hit && iot_i.op == OP_MAINT_STEP && !irq_flag_clear_i
		|=> maint_mode_o)
		else $error("Enter command did not set maintenance mode");
	no_mode_free_a: assert property ( // [RULE_03]
		ce_i && !maint_mode_o && !(iot_hit && iot_i.op == OP_MAINT_STEP)
		|=> !maint_mode_o)
		else $error("Maintenance mode set without enter command");
	leave_mode_a: assert property ( // [RULE_04]
		ce_i && irq_flag_clear_i
		|=> !maint_mode_o && !halt_o)
		else $error("Maintenance mode kept after flag clear");
	mode_hold_a: assert property ( // [RULE_04]
		ce_i && maint_mode_o && !irq_flag_clear_i
		|=> maint_mode_o)
		else $error("Maintenance mode lost without flag clear");

	// Readback into the accumulator
	or_merge_a: assert property ( // [RULE_05]
		ce_i && iot_hit && iot_i.op != OP_LOAD_SC && iot_i.op != 3'h0
		|=> ac_valid_o && ((ac_o & $past(iot_i.ac)) == $past(iot_i.ac)))
		else $error("Readback overwrote accumulator bits");
	step_ac_a: assert property ( // [RULE_05]
		ce_i && iot_hit && iot_i.op == OP_MAINT_STEP
		|=> ac_valid_o && ac_o == $past(iot_i.ac))
		else $error("Step command changed the accumulator");
	ac_pulse_a: assert property ( // [RULE_05]
		ce_i && !iot_hit
		|=> !ac_valid_o)
		else $error("Accumulator strobe without a command");
	ac_hold_a: assert property ( // [RULE_05]
		ce_i && !iot_hit
		|=> $stable(ac_o))
		else $error("Accumulator changed without a command");
	op_zero_a: assert property ( // [RULE_05]
		ce_i && iot_hit && iot_i.op == 3'h0
		|=> !ac_valid_o && $stable(ac_o))
		else $error("Op zero was not ignored");
	refused_off_a: assert property (
		ce_i && iot_i.valid && !st.iot_en
		|=> !ac_valid_o)
		else $error("Command answered while disabled");
	states_map_a: assert property ( // [RULE_06]
		ce_i && iot_hit && iot_i.op == OP_READ_STATES
		|=> ac_o[AC_STATE_MSB:AC_STATE_LSB] == ($past(iot_i.ac[AC_STATE_MSB:AC_STATE_LSB]) | $past(core_i.time_state)))
		else $error("Time state counter misplaced");
	major_map_a: assert property ( // [RULE_07]
		ce_i && iot_hit && iot_i.op == OP_READ_STATES
		|=> ac_o[AC_MAJOR_MSB:AC_MAJOR_LSB] == ($past(iot_i.ac[AC_MAJOR_MSB:AC_MAJOR_LSB]) | $past(core_i.major)))
		else $error("Major state flags misplaced");
	option_bits_a: assert property ( // [RULE_08]
		ce_i && iot_hit && iot_i.op == OP_READ_STATES && ext_option_i
		|=> ac_o[AC_SPECIAL] == ($past(iot_i.ac[AC_SPECIAL]) | $past(core_i.special))
		&& ac_o[AC_XT_EXEC] == ($past(iot_i.ac[AC_XT_EXEC]) | $past(core_i.xt_exec)))
		else $error("Special or extended execute state misplaced");
	option_gate_a: assert property ( // [RULE_18]
		ce_i && iot_hit && iot_i.op == OP_READ_STATES && !ext_option_i
		|=> ac_o[AC_SPECIAL:AC_XT_EXEC] == $past(iot_i.ac[AC_SPECIAL:AC_XT_EXEC]))
		else $error("Bits 10-11 set without option");
	o_upper_a: assert property ( // [RULE_09]
		ce_i && iot_hit && iot_i.op == OP_READ_O_UP
		|=> ac_o == ($past(iot_i.ac) | $past(core_i.o_reg[O_UPPER_TOP -: 12])))
		else $error("Upper O word read wrong");
	o_lower_a: assert property ( // [RULE_10]
		ce_i && iot_hit && iot_i.op == OP_READ_O_LOW
		|=> ac_o == ($past(iot_i.ac) | $past(core_i.o_reg[O_LOWER_TOP -: 12])))
		else $error("Lower O word read wrong");
	ptr_read_a: assert property ( // [RULE_11]
		ce_i && iot_hit && iot_i.op == OP_READ_PTR
		|=> ac_o == ($past(iot_i.ac) | $past(core_i.ptr)))
		else $error("Table pointer read wrong");
	mq_read_a: assert property ( // [RULE_12]
		ce_i && iot_hit && iot_i.op == OP_READ_MQ
		|=> ac_o == ($past(iot_i.ac) | $past(core_i.mq_low)))
		else $error("Multiplier-quotient word read wrong");

	// Shift counter load and extension words
	sc_load_a: assert property ( // [RULE_13] [RULE_14]
		ce_i && iot_hit && iot_i.op == OP_LOAD_SC
		|=> shift_load_o && shift_cnt_o == $past(iot_i.ac[AC_SC_MSB:AC_SC_LSB])
		&& ext_prec_o == $past(iot_i.ac[AC_XP_SEL]))
		else $error("Shift counter or precision load wrong");
	sc_pulse_a: assert property ( // [RULE_13]
		ce_i && !(iot_hit && iot_i.op == OP_LOAD_SC)
		|=> !shift_load_o)
		else $error("Shift load strobe without a load");
	sc_hold_a: assert property ( // [RULE_13] [RULE_14]
		ce_i && !(iot_hit && iot_i.op == OP_LOAD_SC)
		|=> $stable(shift_cnt_o) && $stable(ext_prec_o))
		else $error("Shift counter or precision changed without a load");
	ext_clear_a: assert property ( // [RULE_16]
		ce_i && iot_hit && iot_i.op == OP_LOAD_SC
		&& {iot_i.ac[AC_EXT1_SEL], iot_i.ac[AC_EXT2_SEL], iot_i.ac[AC_EXT3_SEL]} == 3'b000
		|=> ac_o == 12'h000)
		else $error("Accumulator not cleared by shift counter load");
	ext_word_a: assert property ( // [RULE_15]
		ce_i && iot_hit && iot_i.op == OP_LOAD_SC
		&& {iot_i.ac[AC_EXT1_SEL], iot_i.ac[AC_EXT2_SEL], iot_i.ac[AC_EXT3_SEL]} == 3'b100
		|=> ac_o == $past(core_i.o_reg[O_EXT1_TOP -: 12]))
		else $error("Wrong O extension word");
	ext_mid_a: assert property ( // [RULE_15]
		ce_i && iot_hit && iot_i.op == OP_LOAD_SC
		&& {iot_i.ac[AC_EXT1_SEL], iot_i.ac[AC_EXT2_SEL], iot_i.ac[AC_EXT3_SEL]} == 3'b010
		|=> ac_o == $past(core_i.o_reg[O_EXT2_TOP -: 12]))
		else $error("Wrong second O extension word");
	ext_low_a: assert property ( // [RULE_15]
		ce_i && iot_hit && iot_i.op == OP_LOAD_SC
		&& {iot_i.ac[AC_EXT1_SEL], iot_i.ac[AC_EXT2_SEL], iot_i.ac[AC_EXT3_SEL]} == 3'b001
		|=> ac_o == $past(core_i.o_reg[O_EXT3_TOP -: 12]))
		else $error("Wrong third O extension word");

	// Register port
	rdata_idle_a: assert property (
		ce_i && !reg_i.rd
		|=> rdata_o == 16'h0000)
		else $error("Read data shown without a read");
	ctrl_read_a: assert property (
		ce_i && reg_i.rd && reg_i.addr == ADDR_CTRL
		|=> rdata_o[15:1] == 15'h0000 && rdata_o[CTRL_IOT_EN] == $past(st.iot_en))
		else $error("Control read wrong");
	status_read_a: assert property (
		ce_i && reg_i.rd && reg_i.addr == ADDR_STATUS
		|=> rdata_o[STAT_MAINT] == $past(maint_mode_o) && rdata_o[STAT_HALTED] == $past(halt_o)
		&& rdata_o[STAT_SC_LSB +: 6] == $past(shift_cnt_o) && rdata_o[STAT_TS_LSB +: 4] == $past(core_i.time_state))
		else $error("Status read wrong");
	unmapped_read_a: assert property (
		ce_i && reg_i.rd && reg_i.addr > ADDR_STATUS
		|=> rdata_o == 16'h0000)
		else $error("Unmapped read not zero");
	ctrl_write_a: assert property (
		ce_i && reg_i.wr && reg_i.addr == ADDR_CTRL
		|=> st.iot_en == $past(reg_i.wdata[CTRL_IOT_EN]))
		else $error("Control write did not land");

	step_seen_c: cover property (ce_i && halt_o ##1 step_o);
	read_states_c: cover property (ce_i && iot_hit && iot_i.op == OP_READ_STATES);
	ext_read_c: cover property (ce_i && iot_hit && iot_i.op == OP_LOAD_SC && iot_i.ac[AC_EXT3_SEL]);
	leave_halted_c: cover property (halt_o && irq_flag_clear_i && ce_i);
	ptr_read_c: cover property (ce_i && iot_hit && iot_i.op == OP_READ_PTR);
endmodule

// ==== sim/host_model.sv ====
// Host processor model issuing I/O transfer instructions
module host_model
	import maint_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        ac_valid_i,
	input  wire logic [11:0] ac_i,
	output iot_req_t         iot_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial iot_o = '0;
	// Enter-maintenance is issued ahead of any start by the bench order
	task automatic io_transfer_instruction(input logic [2:0] op, input logic [11:0] ac, output logic [11:0] res, output logic got);
		got = 1'b0;
		res = 'x;
		@(posedge clk_sys_i);
		iot_o <= '{1'b1, MAINT_DEV_CODE, op, ac};
		@(posedge clk_sys_i);
		// Released data lines show the inverse, never a stale match
		iot_o <= '{1'b0, ~MAINT_DEV_CODE, op, ~ac};
		for (int i = 0; i < 3 && !got; i++) begin
			if (i > 0) @(posedge clk_sys_i);
			#1;
			if (ac_valid_i === 1'b1) begin
				got = 1'b1;
				res = ac_i;
			end
		end
	endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the maintenance step and readback block
module testbench
	import maint_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0, nrst_i = 0, ext_option_i = 1, state_end_i = 0, irq_flag_clear_i = 0;
	reg_req_t reg_i = '0;
	core_view_t core_i = '{4'hA, 6'h2D, 1'b1, 1'b1, 60'h123456789ABCDEF, 12'h5A5, 12'hC3C};
	iot_req_t io_transfer_instruction;
	logic [11:0] ac_o;
	logic [5:0] shift_cnt_o;
	logic [15:0] rdata_o;
	logic ac_valid_o, maint_mode_o, halt_o, step_o, shift_load_o, ext_prec_o;
	int bad_count = 0, cmp_count = 0;
	wire logic [59:0] o = core_i.o_reg;
	always #12.5 clk_sys_i = ~clk_sys_i;
	maintenance_step_readback u_dut(.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1),
		.ext_option_i(ext_option_i), .iot_i(io_transfer_instruction), .core_i(core_i), .state_end_i(state_end_i),
		.irq_flag_clear_i(irq_flag_clear_i), .reg_i(reg_i), .ac_o(ac_o), .ac_valid_o(ac_valid_o),
		.maint_mode_o(maint_mode_o), .halt_o(halt_o), .step_o(step_o), .shift_cnt_o(shift_cnt_o),
		.shift_load_o(shift_load_o), .ext_prec_o(ext_prec_o), .rdata_o(rdata_o));
	host_model u_host(.clk_sys_i(clk_sys_i), .ac_valid_i(ac_valid_o), .ac_i(ac_o), .iot_o(io_transfer_instruction));
	task chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task io(input logic [2:0] op, input logic [11:0] ac, input logic g_exp, input logic [11:0] e);
		logic [11:0] r;
		logic g;
		u_host.io_transfer_instruction(op, ac, r, g);
		chk({15'h0, g}, {15'h0, g_exp});
		if (g_exp) chk({4'h0, r}, {4'h0, e});
	endtask
	task acc(input logic [1:0] a, input logic [15:0] d, input logic w, input logic [15:0] e);
		@(posedge clk_sys_i);
		reg_i <= '{a, d, w, !w};
		@(posedge clk_sys_i);
		reg_i <= '0;
		#1;
		if (!w) chk(rdata_o, e);
	endtask
	task pulse(input logic se, input logic fc);
		@(posedge clk_sys_i);
		state_end_i <= se;
		irq_flag_clear_i <= fc;
		@(posedge clk_sys_i);
		state_end_i <= 1'b0;
		irq_flag_clear_i <= 1'b0;
		#1;
	endtask
	task print_verdict;
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#(25 * 4000);
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (8) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		acc(ADDR_CTRL, 0, 0, 16'h0001);
		acc(2'h2, 0, 0, 16'h0000);
		acc(ADDR_CTRL, 0, 1, 0);
		io(OP_READ_PTR, 0, 0, 0);
		acc(ADDR_CTRL, 1, 1, 0);
		// Step outside mode only enters mode
		io(OP_MAINT_STEP, 12'h123, 1, 12'h123);
		chk(step_o, 0);
		chk(maint_mode_o, 1);
		pulse(1, 0);
		chk(halt_o, 1);
		acc(ADDR_STATUS, 0, 0, 16'hA003);
		io(OP_MAINT_STEP, 0, 1, 0);
		chk(step_o, 1);
		chk(halt_o, 0);
		pulse(1, 0);
		pulse(0, 1);
		chk({maint_mode_o, halt_o}, 0);
		pulse(1, 0);
		chk(halt_o, 0);
		io(OP_READ_STATES, 0, 1, {4'hA, 6'h2D, 2'b11});
		@(posedge clk_sys_i);
		ext_option_i <= 1'b0;
		io(OP_READ_STATES, 12'h001, 1, {4'hA, 6'h2D, 2'b01});
		io(OP_READ_O_UP, 12'h801, 1, 12'h801 | o[59:48]);
		io(OP_READ_O_LOW, 12'h801, 1, 12'h801 | o[47:36]);
		io(OP_READ_MQ, 12'h801, 1, 12'h801 | 12'hC3C);
		io(OP_READ_PTR, 12'h00A, 1, 12'h5AF);
		io(OP_LOAD_SC, 12'h925, 1, o[35:24]);
		chk({shift_load_o, ext_prec_o, shift_cnt_o}, 16'h00E5);
		io(OP_LOAD_SC, 12'h680, 1, o[23:12]);
		chk(ext_prec_o, 0);
		io(OP_LOAD_SC, 12'h040, 1, o[11:0]);
		io(OP_LOAD_SC, 12'h03F, 1, 0);
		io(3'h0, 12'hFFF, 0, 0);
		chk(ac_o, 0);
		acc(ADDR_STATUS, 0, 0, 16'hA3F0);
		print_verdict();
	end
endmodule
